// >>> uds_pkg.sv
// package: register map, fields, reset values and carriers for the serial data path
//==============================================================================
package uds_pkg;
  //==============================================================================
  // register byte addresses
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FRAME_CTRL = 8'h08;
  localparam logic [7:0] ADDR_ENABLE_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_DATA = 8'h10;
  localparam logic [7:0] ADDR_BAUD = 8'h14;
  //==============================================================================
  // reset values
  localparam logic [7:0] MODE_CTRL_RST = 8'hE0;
  localparam logic [7:0] STATUS_RST = 8'h0B;
  localparam logic [7:0] FRAME_CTRL_RST = 8'h00;
  localparam logic [7:0] ENABLE_CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  //==============================================================================
  // field positions
  localparam int MODE_SEL_BIT = 4;
  localparam int GLOBAL_EN_BIT = 7;
  localparam int NINE_BIT_BIT = 6;
  localparam int PARITY_EN_BIT = 5;
  localparam int PARITY_ODD_BIT = 4;
  localparam int TWO_STOP_BIT = 3;
  localparam int BREAK_BIT = 2;
  localparam int RX_BIT8_BIT = 1;
  localparam int TX_BIT8_BIT = 0;
  localparam int TX_EN_BIT = 7;
  localparam int RX_EN_BIT = 6;
  localparam int RX_IRQ_EN_BIT = 2;
  //==============================================================================
  // timing: 16 ticks per bit, break of at least 13 bit times
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] MID_SAMPLE = 4'h7;
  localparam logic [4:0] BREAK_BITS = 5'h0D;
  localparam int RX_DEPTH = 2;

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_BREAK} uds_txst_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uds_rxst_e;

  // one received word with its error marks
  typedef struct packed {
    logic [8:0] data;
    logic parityErr;
    logic noise;
    logic frameErr;
  } uds_rxword_s;

  typedef struct packed {
    logic parityErr;
    logic noise;
    logic frameErr;
    logic overrun;
    logic rxIdle;
    logic rxAvail;
    logic txIdle;
    logic txEmpty;
  } uds_status_s;
endpackage

// >>> uds_core.sv
// module: serial transceiver data path, status flags and apb register slave
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
module uds_core #(
  parameter int DIV_WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  output logic txdOe,
  output logic rxIrq
);
  typedef struct packed {
    logic [7:0] modeCtrl;
    logic [7:0] frameCtrl;
    logic [7:0] enableCtrl;
    logic [DIV_WIDTH-1:0] baudDiv;
    logic [DIV_WIDTH-1:0] baudCnt;
    logic [2:0] rxSync;
    logic rxLine;
    uds_pkg::uds_status_s stat;
    logic statRead;
    logic [8:0] txHold;
    logic [10:0] txShift;
    logic [3:0] txBits;
    logic [3:0] txTick;
    logic [4:0] brkBits;
    uds_pkg::uds_txst_e txSt;
    uds_pkg::uds_rxst_e rxSt;
    logic [3:0] rxTick;
    logic [3:0] rxBits;
    logic [9:0] rxShift;
    logic [2:0] rxSamp;
    logic rxNoise;
    logic rxPar;
    uds_pkg::uds_rxword_s [1:0] fifo;
    logic [1:0] fifoCnt;
    uds_pkg::uds_rxword_s dataReg;
    logic [31:0] rdata;
    logic irq;
  } uds_state_s;

  uds_state_s q;
  uds_state_s d;

  logic active;
  logic tick;
  logic wrAcc;
  logic rdAcc;
  logic dataAcc;
  logic [3:0] dataBits;
  logic rxStopDone;
  logic majority;
  uds_pkg::uds_rxword_s newWord;
  logic [7:0] statByte;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = q.rdata;
  assign txd = q.txSt == uds_pkg::TX_SHIFT ? q.txShift[0] : q.txSt != uds_pkg::TX_BREAK;
  assign txdOe = active & q.enableCtrl[uds_pkg::TX_EN_BIT];
  assign rxIrq = q.irq;

  always_comb begin
    d = q;
    active = q.modeCtrl[uds_pkg::MODE_SEL_BIT] & q.frameCtrl[uds_pkg::GLOBAL_EN_BIT];
    tick = 1'b0;
    wrAcc = psel & penable & pwrite;
    rdAcc = psel & penable & ~pwrite;
    dataAcc = psel & penable & (paddr == uds_pkg::ADDR_DATA);
    dataBits = q.frameCtrl[uds_pkg::NINE_BIT_BIT] ? 4'h9 : 4'h8;
    rxStopDone = 1'b0;
    majority = (q.rxSamp[0] & q.rxSamp[1]) | (q.rxSamp[1] & q.rxSamp[2]) | (q.rxSamp[0] & q.rxSamp[2]);
    newWord = '0;
    statByte = q.stat;
    //==============================================================================
    // pin sampling and shared baud tick
    d.rxSync = {q.rxSync[1:0], rxd};
    if (q.rxSync[2] == q.rxSync[1]) begin
      d.rxLine = q.rxSync[1];
    end
    if (active) begin
      if (q.baudCnt >= q.baudDiv) begin
        d.baudCnt = '0;
        tick = 1'b1;
      end else begin
        d.baudCnt = q.baudCnt + 1'b1;
      end
    end else begin
      d.baudCnt = '0;
    end
    //==============================================================================
    // transmitter
    if (tick) begin
      case (q.txSt)
        uds_pkg::TX_IDLE: begin
          if (q.enableCtrl[uds_pkg::TX_EN_BIT] & q.frameCtrl[uds_pkg::BREAK_BIT]) begin
            d.txSt = uds_pkg::TX_BREAK;
            d.brkBits = '0;
            d.txTick = '0;
          end else if (q.enableCtrl[uds_pkg::TX_EN_BIT] & ~q.stat.txEmpty) begin
            d.txShift = q.frameCtrl[uds_pkg::NINE_BIT_BIT] ? {1'b1, q.txHold, 1'b0}
                                                          : {2'b11, q.txHold[7:0], 1'b0};
            d.txBits = dataBits + 4'h1 + (q.frameCtrl[uds_pkg::TWO_STOP_BIT] ? 4'h2 : 4'h1);
            d.txTick = '0;
            d.txSt = uds_pkg::TX_SHIFT;
            d.stat.txEmpty = 1'b1;
          end
        end
        uds_pkg::TX_SHIFT: begin
          d.txTick = q.txTick + 4'h1;
          if (q.txTick == uds_pkg::OVERSAMPLE_LAST) begin
            d.txShift = {1'b1, q.txShift[10:1]};
            d.txBits = q.txBits - 4'h1;
            if (q.txBits == 4'h1) begin
              d.txSt = uds_pkg::TX_IDLE;
            end
          end
        end
        default: begin
          d.txTick = q.txTick + 4'h1;
          if (q.txTick == uds_pkg::OVERSAMPLE_LAST && q.brkBits != uds_pkg::BREAK_BITS) begin
            d.brkBits = q.brkBits + 5'h01;
          end
          if (q.brkBits == uds_pkg::BREAK_BITS && !q.frameCtrl[uds_pkg::BREAK_BIT]) begin
            d.txSt = uds_pkg::TX_IDLE;
          end
        end
      endcase
    end
    d.stat.txIdle = q.stat.txEmpty & (d.txSt == uds_pkg::TX_IDLE) & ~q.frameCtrl[uds_pkg::BREAK_BIT];
    //==============================================================================
    // receiver, 16x oversampled with 3-sample majority
    if (tick && q.enableCtrl[uds_pkg::RX_EN_BIT]) begin
      d.rxTick = q.rxTick + 4'h1;
      if (q.rxTick >= MID_M1() && q.rxTick <= MID_P1()) begin
        d.rxSamp = {q.rxSamp[1:0], q.rxLine};
      end
      case (q.rxSt)
        uds_pkg::RX_IDLE: begin
          d.rxTick = '0;
          if (!q.rxLine) begin
            d.rxSt = uds_pkg::RX_START;
            d.rxNoise = 1'b0;
          end
        end
        uds_pkg::RX_START: begin
          if (q.rxTick == uds_pkg::OVERSAMPLE_LAST) begin
            if (majority) begin
              d.rxSt = uds_pkg::RX_IDLE;
            end else begin
              d.rxSt = uds_pkg::RX_DATA;
              d.rxBits = '0;
              d.rxPar = 1'b0;
            end
          end
        end
        uds_pkg::RX_DATA: begin
          if (q.rxTick == uds_pkg::OVERSAMPLE_LAST) begin
            d.rxShift = {majority, q.rxShift[9:1]};
            d.rxPar = q.rxPar ^ majority;
            d.rxNoise = q.rxNoise | ~(&q.rxSamp | ~|q.rxSamp);
            d.rxBits = q.rxBits + 4'h1;
            if (q.rxBits == dataBits - 4'h1 + {3'h0, q.frameCtrl[uds_pkg::PARITY_EN_BIT]}) begin
              d.rxSt = uds_pkg::RX_STOP;
            end
          end
        end
        default: begin
          if (q.rxTick == uds_pkg::OVERSAMPLE_LAST) begin
            rxStopDone = 1'b1;
            d.rxSt = uds_pkg::RX_IDLE;
          end
        end
      endcase
    end
    d.stat.rxIdle = d.rxSt == uds_pkg::RX_IDLE;
    if (rxStopDone) begin
      // bits enter at the top, so a trailing parity bit pushes the data one place lower
      if (q.frameCtrl[uds_pkg::NINE_BIT_BIT]) begin
        newWord.data = q.frameCtrl[uds_pkg::PARITY_EN_BIT] ? q.rxShift[8:0] : q.rxShift[9:1];
      end else begin
        newWord.data = {1'b0, q.frameCtrl[uds_pkg::PARITY_EN_BIT] ? q.rxShift[8:1] : q.rxShift[9:2]};
      end
      if (q.frameCtrl[uds_pkg::PARITY_EN_BIT]) begin
        newWord.parityErr = (q.rxPar != q.frameCtrl[uds_pkg::PARITY_ODD_BIT]);
      end
      newWord.noise = q.rxNoise | ~(&q.rxSamp | ~|q.rxSamp);
      newWord.frameErr = ~majority;
    end
    //==============================================================================
    // register access and read-then-access flag clearing
    if (rdAcc && paddr == uds_pkg::ADDR_STATUS) begin
      d.statRead = 1'b1;
    end
    if (dataAcc && q.statRead) begin
      d.statRead = 1'b0;
      d.stat.parityErr = 1'b0;
      d.stat.noise = 1'b0;
      d.stat.frameErr = 1'b0;
      d.stat.overrun = 1'b0;
    end
    if (wrAcc) begin
      if (paddr == uds_pkg::ADDR_MODE_CTRL) begin
        d.modeCtrl = pwdata[7:0];
      end else if (paddr == uds_pkg::ADDR_FRAME_CTRL) begin
        d.frameCtrl = {pwdata[7:2], q.frameCtrl[uds_pkg::RX_BIT8_BIT], pwdata[0]};
      end else if (paddr == uds_pkg::ADDR_ENABLE_CTRL) begin
        d.enableCtrl = pwdata[7:0];
        if (pwdata[uds_pkg::TX_EN_BIT] && !q.enableCtrl[uds_pkg::TX_EN_BIT]) begin
          d.stat.txEmpty = 1'b1;
        end
      end else if (paddr == uds_pkg::ADDR_DATA) begin
        d.txHold = {q.frameCtrl[uds_pkg::TX_BIT8_BIT], pwdata[7:0]};
        if (q.statRead) begin
          d.stat.txEmpty = 1'b0;
          d.stat.txIdle = 1'b0;
        end
      end else if (paddr == uds_pkg::ADDR_BAUD) begin
        d.baudDiv = pwdata[DIV_WIDTH-1:0];
      end
    end
    // pop the data register on a read that follows a status read
    if (rdAcc && paddr == uds_pkg::ADDR_DATA && q.statRead && q.stat.rxAvail) begin
      if (q.fifoCnt != 2'h0) begin
        d.dataReg = q.fifo[0];
        d.fifo[0] = q.fifo[1];
        d.fifoCnt = q.fifoCnt - 2'h1;
      end else begin
        d.stat.rxAvail = 1'b0;
      end
    end
    // a finished word lands after the pop so a same-cycle arrival is kept unless overrun is already set
    if (rxStopDone) begin
      if (q.stat.overrun || d.fifoCnt == 2'(uds_pkg::RX_DEPTH)) begin
        d.stat.overrun = 1'b1;
      end else if (!d.stat.rxAvail) begin
        d.dataReg = newWord;
        d.stat.rxAvail = 1'b1;
        d.stat.parityErr = newWord.parityErr;
        d.stat.noise = newWord.noise;
        d.stat.frameErr = newWord.frameErr;
      end else begin
        d.fifo[d.fifoCnt[0]] = newWord;
        d.fifoCnt = d.fifoCnt + 2'h1;
      end
    end
    d.frameCtrl[uds_pkg::RX_BIT8_BIT] = d.dataReg.data[8];
    d.irq = d.stat.rxAvail & d.enableCtrl[uds_pkg::RX_IRQ_EN_BIT];
    //==============================================================================
    // read data; status is read only, unmapped reads as zero
    d.rdata = '0;
    if (psel && !penable && !pwrite) begin
      if (paddr == uds_pkg::ADDR_MODE_CTRL) begin
        d.rdata = {24'h000000, q.modeCtrl};
      end else if (paddr == uds_pkg::ADDR_STATUS) begin
        d.rdata = {24'h000000, statByte};
      end else if (paddr == uds_pkg::ADDR_FRAME_CTRL) begin
        d.rdata = {24'h000000, q.frameCtrl[7:1], 1'b0};
      end else if (paddr == uds_pkg::ADDR_ENABLE_CTRL) begin
        d.rdata = {24'h000000, q.enableCtrl};
      end else if (paddr == uds_pkg::ADDR_DATA) begin
        d.rdata = {24'h000000, q.dataReg.data[7:0]};
      end else if (paddr == uds_pkg::ADDR_BAUD) begin
        d.rdata = {{(32 - DIV_WIDTH){1'b0}}, q.baudDiv};
      end
    end else if (psel && penable && !pwrite) begin
      d.rdata = q.rdata;
    end
    //==============================================================================
    // global disable: flags to reset values, buffers discarded, config kept except break and both enables, cleared in serial mode
    if (!active) begin
      d.stat = uds_pkg::STATUS_RST;
      d.statRead = 1'b0;
      d.fifoCnt = '0;
      d.txSt = uds_pkg::TX_IDLE;
      d.rxSt = uds_pkg::RX_IDLE;
      d.frameCtrl[uds_pkg::BREAK_BIT] = q.modeCtrl[uds_pkg::MODE_SEL_BIT] ? 1'b0 : d.frameCtrl[uds_pkg::BREAK_BIT];
      d.irq = 1'b0;
      if (q.modeCtrl[uds_pkg::MODE_SEL_BIT]) begin
        d.enableCtrl[uds_pkg::TX_EN_BIT] = 1'b0;
        d.enableCtrl[uds_pkg::RX_EN_BIT] = 1'b0;
      end
    end
  end

  function automatic logic [3:0] MID_M1();
    return uds_pkg::MID_SAMPLE - 4'h1;
  endfunction

  function automatic logic [3:0] MID_P1();
    return uds_pkg::MID_SAMPLE + 4'h1;
  endfunction

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.modeCtrl <= uds_pkg::MODE_CTRL_RST;
      q.frameCtrl <= uds_pkg::FRAME_CTRL_RST;
      q.enableCtrl <= uds_pkg::ENABLE_CTRL_RST;
      q.baudDiv <= DIV_WIDTH'(uds_pkg::BAUD_RST);
      q.stat <= uds_pkg::STATUS_RST;
      q.rxSync <= 3'h7;
      q.rxLine <= 1'b1;
      q.txSt <= uds_pkg::TX_IDLE;
      q.rxSt <= uds_pkg::RX_IDLE;
    end else begin
      q <= d;
    end
  end
endmodule

// >>> uds_checker.sv
// checker: apb and pin relations of the serial data path
`timescale 1ns/1ps
module uds_checker #(
  parameter int DIV_WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic txd,
  input wire logic txdOe,
  input wire logic rxIrq
);
  // ==========
  // shadow of the enable bits, taken from completed apb writes
  typedef struct packed {logic mode; logic en; logic txEn; logic irqEn;} uds_chk_s;
  uds_chk_s st_q;
  uds_chk_s st_d;
  logic allOn;
  always_comb begin
    st_d = st_q;
    if (psel && penable && pready && pwrite) begin
      if (paddr == uds_pkg::ADDR_MODE_CTRL) st_d.mode = pwdata[uds_pkg::MODE_SEL_BIT];
      if (paddr == uds_pkg::ADDR_FRAME_CTRL) st_d.en = pwdata[uds_pkg::GLOBAL_EN_BIT];
      if (paddr == uds_pkg::ADDR_ENABLE_CTRL) st_d.txEn = pwdata[uds_pkg::TX_EN_BIT];
      if (paddr == uds_pkg::ADDR_ENABLE_CTRL) st_d.irqEn = pwdata[uds_pkg::RX_IRQ_EN_BIT];
    end
    // serial mode with the function off keeps the transmitter enable cleared
    if (st_q.mode && !st_q.en) st_d.txEn = 1'b0;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) st_q <= '0;
    else st_q <= st_d;
  end
  assign allOn = st_q.mode && st_q.en && st_q.txEn;
  // ==========
  // assertions; two cycles of slack since the pin enables may be registered
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_rd_any;
    psel && !penable && !pwrite ##1 psel && penable;
  endsequence
  sequence s_rd_unmapped;
    psel && !penable && !pwrite && paddr > uds_pkg::ADDR_BAUD ##1 psel && penable;
  endsequence
  a_pready_access: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_no_slave_error: assert property (psel && penable |-> !pslverr)
    else $error("pslverr raised");
  a_unmapped_zero: assert property (s_rd_unmapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_upper_bits_zero: assert property (s_rd_any |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_prdata_idle: assert property (!psel && !$past(psel) |-> prdata == 32'h0)
    else $error("read data not zero while idle");
  a_oe_needs_on: assert property (!allOn && !$past(allOn) && !$past(allOn, 2) |-> !txdOe)
    else $error("txd driven while serial function off");
  a_oe_follows_on: assert property (allOn && $past(allOn) && $past(allOn, 2) |-> txdOe)
    else $error("txd not driven while serial function on");
  a_txd_high_off: assert property (!allOn && !$past(allOn) && !$past(allOn, 2) |-> txd)
    else $error("txd low while transmitter off");
  a_irq_needs_en: assert property (!st_q.irqEn && !$past(st_q.irqEn) |-> !rxIrq)
    else $error("interrupt without enable");
endmodule
bind uds_core uds_checker #(.DIV_WIDTH(DIV_WIDTH)) i_chk (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxd(rxd), .txd(txd), .txdOe(txdOe), .rxIrq(rxIrq));

// >>> uds_serial_peer.sv
// model: serial device on the far side of txd and rxd
`timescale 1ns/1ps
module uds_serial_peer #(
  parameter int BIT_CLKS = 16
) (
  input wire logic ref_clk,
  input wire logic txd,
  output logic rxd
);
  logic [7:0] gotByte;
  int gotCnt;
  initial begin
    rxd = 1'b1;
    gotCnt = 0;
    gotByte = 8'h00;
  end
  // ==========
  // one frame: start, 8 data lsb first, optional parity, stop; line rests high
  task automatic sendByte(input logic [7:0] d, input logic usePar, input logic par, input logic stopLvl);
    @(posedge ref_clk);
    rxd <= 1'b0;
    repeat (BIT_CLKS) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      rxd <= d[i];
      repeat (BIT_CLKS) @(posedge ref_clk);
    end
    if (usePar) begin
      rxd <= par;
      repeat (BIT_CLKS) @(posedge ref_clk);
    end
    rxd <= stopLvl;
    repeat (BIT_CLKS) @(posedge ref_clk);
    rxd <= 1'b1;
    repeat (BIT_CLKS) @(posedge ref_clk);
  endtask
  // ==========
  // receiver samples mid-bit; a frame without a high stop bit is not counted
  initial begin
    forever begin
      @(posedge ref_clk);
      if (txd === 1'b0) begin
        repeat (BIT_CLKS / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CLKS) @(posedge ref_clk);
          gotByte[i] = txd;
        end
        repeat (BIT_CLKS) @(posedge ref_clk);
        if (txd === 1'b1) gotCnt++;
      end
    end
  end
endmodule

// >>> uart_datapath_status_bench.sv
// testbench: register sequences and serial traffic for the data path
`timescale 1ns/1ps
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin errorCnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module uart_datapath_status_bench;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, rxd, txd, txdOe, rxIrq;
  logic [7:0] paddr, rd;
  logic [31:0] pwdata, prdata;
  logic [7:0] burst [4] = '{8'h81, 8'h42, 8'h24, 8'h18};
  int errorCnt, checksDone, k;
  uds_core #(.DIV_WIDTH(8)) i_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .txdOe(txdOe), .rxIrq(rxIrq));
  uds_serial_peer #(.BIT_CLKS(16)) i_peer (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ==========
  // shared tasks
  task automatic endSim;
    $display("checks %0d errors %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errorCnt++;
      endSim();
    end
    rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // polls status a bounded number of times, then compares
  task automatic waitStat(input logic [7:0] e);
    for (int i = 0; i < 60; i++) begin
      apbXfer(1'b0, uds_pkg::ADDR_STATUS, 8'h00);
      if (rd === e) break;
    end
    `CHK(rd, e)
  endtask
  // ==========
  // main sequence
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata, rd} = '0;
    errorCnt = 0;
    checksDone = 0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    apbXfer(1'b0, uds_pkg::ADDR_MODE_CTRL, 8'h00);
    `CHK(rd, uds_pkg::MODE_CTRL_RST)
    apbXfer(1'b1, uds_pkg::ADDR_STATUS, 8'hF4);
    waitStat(uds_pkg::STATUS_RST);
    apbXfer(1'b0, 8'h18, 8'h00);
    `CHK(rd, 8'h00)
    apbXfer(1'b1, uds_pkg::ADDR_MODE_CTRL, 8'h10);
    apbXfer(1'b1, uds_pkg::ADDR_FRAME_CTRL, 8'h80);
    apbXfer(1'b1, uds_pkg::ADDR_ENABLE_CTRL, 8'hC4);
    waitStat(8'h0B);
    `CHK(txdOe, 1'b1)
    apbXfer(1'b1, uds_pkg::ADDR_DATA, 8'hA5);
    apbXfer(1'b0, uds_pkg::ADDR_STATUS, 8'h00);
    `CHK(rd[1], 1'b0)
    for (k = 0; k < 400 && i_peer.gotCnt == 0; k++) @(posedge ref_clk);
    `CHK(i_peer.gotByte, 8'hA5)
    waitStat(8'h0B);
    fork
      i_peer.sendByte(8'h3C, 1'b0, 1'b0, 1'b1);
      begin
        repeat (48) @(posedge ref_clk);
        apbXfer(1'b0, uds_pkg::ADDR_STATUS, 8'h00);
        `CHK(rd[3], 1'b0)
      end
    join
    waitStat(8'h0F);
    `CHK(rxIrq, 1'b1)
    apbXfer(1'b0, uds_pkg::ADDR_DATA, 8'h00);
    `CHK(rd, 8'h3C)
    waitStat(8'h0B);
    // stop bit held low: framing flag arrives with the word
    i_peer.sendByte(8'h55, 1'b0, 1'b0, 1'b0);
    waitStat(8'h2F);
    apbXfer(1'b0, uds_pkg::ADDR_DATA, 8'h00);
    `CHK(rd, 8'h55)
    waitStat(8'h0B);
    // four words with no reads: data register plus two buffered, last one lost
    for (k = 0; k < 4; k++) i_peer.sendByte(burst[k], 1'b0, 1'b0, 1'b1);
    waitStat(8'h1F);
    for (k = 0; k < 3; k++) begin
      apbXfer(1'b0, uds_pkg::ADDR_STATUS, 8'h00);
      apbXfer(1'b0, uds_pkg::ADDR_DATA, 8'h00);
      `CHK(rd, burst[k])
    end
    waitStat(8'h0B);
    // even parity with a wrong parity bit, then a status read and data read clear flags
    apbXfer(1'b1, uds_pkg::ADDR_FRAME_CTRL, 8'hA0);
    i_peer.sendByte(8'h01, 1'b1, 1'b0, 1'b1);
    waitStat(8'h8F);
    apbXfer(1'b0, uds_pkg::ADDR_DATA, 8'h00);
    `CHK(rd, 8'h01)
    waitStat(8'h0B);
    // odd parity with an even count of ones
    apbXfer(1'b1, uds_pkg::ADDR_FRAME_CTRL, 8'hB0);
    i_peer.sendByte(8'h01, 1'b1, 1'b1, 1'b1);
    waitStat(8'h8F);
    apbXfer(1'b1, uds_pkg::ADDR_FRAME_CTRL, 8'h00);
    waitStat(8'h0B);
    `CHK(txdOe, 1'b0)
    apbXfer(1'b1, uds_pkg::ADDR_FRAME_CTRL, 8'h80);
    apbXfer(1'b1, uds_pkg::ADDR_ENABLE_CTRL, 8'hC4);
    endSim();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    errorCnt++;
    endSim();
  end
endmodule
